// ===== design/css_pkg.sv
// Package of constants and types for the cascaded supply sequencer
package css_pkg;
  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CSS_CLK_HZ = 25000000;
  localparam int unsigned CSS_ENABLE_START_MS = 10;
  localparam int unsigned CSS_LOCKOUT_DELAY_MS = 80;
  localparam int unsigned CSS_RESET_RELEASE_DELAY_MS = 80;
  localparam int unsigned CSS_ENABLE_START_CYC = CSS_ENABLE_START_MS * (CSS_CLK_HZ / 1000);
  localparam int unsigned CSS_LOCKOUT_DELAY_CYC = CSS_LOCKOUT_DELAY_MS * (CSS_CLK_HZ / 1000);
  localparam int unsigned CSS_RESET_RELEASE_DELAY_CYC = CSS_RESET_RELEASE_DELAY_MS * (CSS_CLK_HZ / 1000);
  localparam int unsigned CSS_FAULT_PULSE_CYC = 4;
  localparam int unsigned CSS_NUM_CH = 4;
  localparam int unsigned CSS_TMR_W = 24;

  // ==========================================================================
  // Sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    CSS_IDLE,
    CSS_START_WAIT,
    CSS_RAMP_ON,
    CSS_LOCKOUT,
    CSS_RELEASE_WAIT,
    CSS_ON,
    CSS_RAMP_OFF
  } css_state_t;
endpackage : css_pkg

// ===== design/css_channel_timer.sv
// One channel delay timer with its switch-drive latch
`timescale 1ns/1ps
module css_channel_timer #(
  parameter int unsigned TMR_W = 24
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_run_on,
  input wire logic i_run_off,
  input wire logic i_kill,
  input wire logic [TMR_W-1:0] i_on_delay,
  input wire logic [TMR_W-1:0] i_off_delay,
  output logic o_drive,
  output logic o_on_done,
  output logic o_off_done
);
  logic [TMR_W-1:0] count_q;
  logic run_on_q;
  logic run_off_q;

  always_ff @(posedge i_clk) begin
    run_on_q <= i_run_on;
    run_off_q <= i_run_off;
  end

  // Counter restarts at each phase change so on and off timing start from zero
  always_ff @(posedge i_clk) begin
    if (i_rst || (i_run_on != run_on_q) || (i_run_off != run_off_q)) begin
      count_q <= '0;
    end else if ((i_run_on && count_q < i_on_delay) || (i_run_off && count_q < i_off_delay)) begin
      count_q <= count_q + TMR_W'(1);
    end
  end

  // Latch set when threshold is reached; cleared by off timing or fault kill
  always_ff @(posedge i_clk) begin
    if (i_rst || i_kill) begin
      o_drive <= 1'b0;
    end else if (i_run_on && run_on_q && count_q >= i_on_delay) begin
      o_drive <= 1'b1;
    end else if (i_run_off && run_off_q && count_q >= i_off_delay) begin
      o_drive <= 1'b0;
    end
  end

  assign o_on_done = o_drive;
  assign o_off_done = ~o_drive;
endmodule : css_channel_timer

// ===== design/css_sequencer.sv
// Top of the cascaded supply sequencer: enable, chaining, fault line, reset
`timescale 1ns/1ps
module css_sequencer
  import css_pkg::*;
#(
  parameter int unsigned NUM_CH = CSS_NUM_CH,
  parameter int unsigned TMR_W = CSS_TMR_W,
  parameter int unsigned START_CYC = CSS_ENABLE_START_CYC,
  parameter int unsigned LOCKOUT_CYC = CSS_LOCKOUT_DELAY_CYC,
  parameter int unsigned RELEASE_CYC = CSS_RESET_RELEASE_DELAY_CYC,
  parameter int unsigned FAULT_PULSE_CYC = CSS_FAULT_PULSE_CYC
) (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_ENABLE,
  input wire logic I_CHAIN_READY,
  input wire logic [NUM_CH-1:0] I_UNDERVOLTAGE_INPUT_OK,
  input wire logic I_SHARED_FAULT_LINE,
  input wire logic [NUM_CH*TMR_W-1:0] I_ON_DELAY,
  input wire logic [NUM_CH*TMR_W-1:0] I_OFF_DELAY,
  output logic [NUM_CH-1:0] O_SWITCH_DRIVE,
  output logic O_SHARED_FAULT_LINE_OE,
  output logic O_SHARED_FAULT_LINE,
  output logic O_RESET_N
);
  // ==========================================================================
  // State and counters
  // ==========================================================================
  css_state_t state_q;
  css_state_t state_d;
  logic [31:0] wait_q;
  logic [7:0] fault_cnt_q;
  logic [NUM_CH-1:0] drive;
  logic [NUM_CH-1:0] on_done;
  logic [NUM_CH-1:0] off_done;
  logic run_on;
  logic run_off;
  logic kill;
  logic uv_all_ok;
  logic fault_seen;
  logic armed;

  assign uv_all_ok = &I_UNDERVOLTAGE_INPUT_OK;
  assign armed = (state_q == CSS_LOCKOUT) || (state_q == CSS_RELEASE_WAIT) || (state_q == CSS_ON);
  // Our own pulse also reads back low, so the driver sees it like other members
  assign fault_seen = ~I_SHARED_FAULT_LINE;
  assign kill = fault_seen && armed;
  assign run_on = (state_q == CSS_RAMP_ON) || armed;
  assign run_off = (state_q == CSS_RAMP_OFF);

  // ==========================================================================
  // Phase timing: start, lockout and release against the one shared wait counter, all-on and all-off from the channel timers
  // ==========================================================================
  logic start_elapsed;
  logic lockout_elapsed;
  logic release_elapsed;
  logic all_on;
  logic all_off;

  // Compared one short of the count because the counter is zero on the entry cycle
  assign start_elapsed = (wait_q >= START_CYC - 1);
  assign lockout_elapsed = (wait_q >= LOCKOUT_CYC - 1);
  assign release_elapsed = (wait_q >= RELEASE_CYC - 1);
  assign all_on = &on_done;
  assign all_off = &off_done;

  // ==========================================================================
  // Channel timers
  // ==========================================================================
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    css_channel_timer #(
      .TMR_W(TMR_W)
    ) u_timer (
      .i_clk(I_MCLK),
      .i_rst(I_SYS_RST),
      .i_run_on(run_on),
      .i_run_off(run_off),
      .i_kill(kill),
      .i_on_delay(I_ON_DELAY[g*TMR_W +: TMR_W]),
      .i_off_delay(I_OFF_DELAY[g*TMR_W +: TMR_W]),
      .o_drive(drive[g]),
      .o_on_done(on_done[g]),
      .o_off_done(off_done[g])
    );
  end

  // ==========================================================================
  // Sequence state machine
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    case (state_q)
      CSS_IDLE: begin
        // A chained group sits here until the stage ahead has released its reset
        if (I_ENABLE && I_CHAIN_READY) begin
          state_d = CSS_START_WAIT;
        end
      end
      CSS_START_WAIT: begin
        if (!I_ENABLE) begin
          state_d = CSS_IDLE;
        end else if (start_elapsed) begin
          state_d = CSS_RAMP_ON;
        end
      end
      CSS_RAMP_ON: begin
        if (!I_ENABLE) begin
          state_d = CSS_RAMP_OFF;
        end else if (all_on && uv_all_ok) begin
          state_d = CSS_LOCKOUT;
        end
      end
      CSS_LOCKOUT: begin
        if (!I_ENABLE || kill) begin
          state_d = CSS_RAMP_OFF;
        end else if (lockout_elapsed) begin
          state_d = CSS_RELEASE_WAIT;
        end
      end
      CSS_RELEASE_WAIT: begin
        // A supply lost on the final edge must still hold reset; the fault pulse follows
        if (!I_ENABLE || kill) begin
          state_d = CSS_RAMP_OFF;
        end else if (release_elapsed && uv_all_ok) begin
          state_d = CSS_ON;
        end
      end
      CSS_ON: begin
        if (!I_ENABLE || kill) begin
          state_d = CSS_RAMP_OFF;
        end
      end
      CSS_RAMP_OFF: begin
        if (all_off && !I_ENABLE) begin
          state_d = CSS_IDLE;
        end else if (all_off && fault_cnt_q == 8'h00 && I_SHARED_FAULT_LINE) begin
          // Fault shutdown waits for enable to cycle before a new start
          state_d = CSS_RAMP_OFF;
        end
      end
      default: state_d = CSS_IDLE;
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      state_q <= CSS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Shared wait counter, cleared on every state change
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST || state_d != state_q) begin
      wait_q <= 32'h0000_0000;
    end else begin
      wait_q <= wait_q + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Fault line pulse: only after turn-on completed
  // ==========================================================================
  // Loaded once per shutdown: the state has left the armed set before it could reload
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      fault_cnt_q <= 8'h00;
    end else if (armed && !uv_all_ok && fault_cnt_q == 8'h00) begin
      fault_cnt_q <= FAULT_PULSE_CYC[7:0];
    end else if (fault_cnt_q != 8'h00) begin
      fault_cnt_q <= fault_cnt_q - 8'h01;
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  // Pulls the wire while armed and our own supply check fails, and then for the rest of the pulse
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_SHARED_FAULT_LINE_OE <= 1'b0;
    end else begin
      O_SHARED_FAULT_LINE_OE <= (armed && !uv_all_ok) || fault_cnt_q > 8'h01;
    end
  end

  // Data side of the open-drain pin stays low; only the enable ever moves
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_SHARED_FAULT_LINE <= 1'b0;
    end else begin
      O_SHARED_FAULT_LINE <= 1'b0;
    end
  end

  // Kill is folded in here so the pins drop on the same edge as the latches
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_SWITCH_DRIVE <= '0;
    end else begin
      O_SWITCH_DRIVE <= drive & {NUM_CH{~kill}};
    end
  end

  // Follows the next state so reset drops on the very edge that sees enable fall
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      O_RESET_N <= 1'b0;
    end else begin
      O_RESET_N <= (state_d == CSS_ON);
    end
  end
endmodule : css_sequencer

// ===== bench/css_seq_properties.sv
// Port checker for the sequencer top, bound below
`timescale 1ns/1ps
module css_seq_properties #(
  parameter int unsigned LOCKOUT_CYC = 30,
  parameter int unsigned RELEASE_CYC = 30
) (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_ENABLE,
  input wire logic I_CHAIN_READY,
  input wire logic [3:0] I_UNDERVOLTAGE_INPUT_OK,
  input wire logic I_SHARED_FAULT_LINE,
  input wire logic [3:0] O_SWITCH_DRIVE,
  input wire logic O_SHARED_FAULT_LINE_OE,
  input wire logic O_RESET_N
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  int unsigned on_q;
  // Slack of two covers the register stages between all-on and release
  always_ff @(posedge I_MCLK) on_q <= (I_SYS_RST || !(&O_SWITCH_DRIVE)) ? 0 : on_q + 1;
  reset_off_a: assert property (
    disable iff (1'b0) I_SYS_RST |=> !O_RESET_N && !O_SHARED_FAULT_LINE_OE && O_SWITCH_DRIVE == 4'h0)
    else $error("outputs active after reset");
  reset_drop_a: assert property ($fell(I_ENABLE) |=> !O_RESET_N)
    else $error("reset not asserted after enable drop");
  start_wait_a: assert property (
    $rose(I_ENABLE) && I_CHAIN_READY && O_SWITCH_DRIVE == 4'h0 |=> (O_SWITCH_DRIVE == 4'h0) [*8])
    else $error("switch on before start delay");
  chain_hold_a: assert property (
    !I_CHAIN_READY && O_SWITCH_DRIVE == 4'h0 |=> O_SWITCH_DRIVE == 4'h0)
    else $error("switch on before upstream ready");
  uv_block_a: assert property ($rose(O_RESET_N) |-> &$past(I_UNDERVOLTAGE_INPUT_OK))
    else $error("release with supply not satisfied");
  release_wait_a: assert property (
    $rose(O_RESET_N) |-> on_q + 2 >= LOCKOUT_CYC + RELEASE_CYC)
    else $error("reset released too early");
  fault_pulse_a: assert property (
    $rose(O_SHARED_FAULT_LINE_OE) |-> O_SHARED_FAULT_LINE_OE [*4] ##1 !O_SHARED_FAULT_LINE_OE)
    else $error("fault pulse length wrong");
  fault_kill_a: assert property (
    $fell(I_SHARED_FAULT_LINE) && O_RESET_N |-> ##[1:4] O_SWITCH_DRIVE == 4'h0)
    else $error("switches kept on after fault");
  cover property ($rose(O_RESET_N));
  cover property ($rose(O_SHARED_FAULT_LINE_OE));
  cover property ($fell(I_ENABLE) && &O_SWITCH_DRIVE);
endmodule : css_seq_properties

bind css_sequencer css_seq_properties #(.LOCKOUT_CYC(LOCKOUT_CYC), .RELEASE_CYC(RELEASE_CYC)) u_css_seq_properties (
  .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_ENABLE(I_ENABLE), .I_CHAIN_READY(I_CHAIN_READY),
  .I_UNDERVOLTAGE_INPUT_OK(I_UNDERVOLTAGE_INPUT_OK), .I_SHARED_FAULT_LINE(I_SHARED_FAULT_LINE),
  .O_SWITCH_DRIVE(O_SWITCH_DRIVE), .O_SHARED_FAULT_LINE_OE(O_SHARED_FAULT_LINE_OE), .O_RESET_N(O_RESET_N));

// ===== bench/css_peer_model.sv
// Peer sequencer on the fault wire and the upstream chain stage
`timescale 1ns/1ps
module css_peer_model (
  input wire logic i_clk,
  input wire logic i_dut_oe,
  input wire logic i_fault_req,
  input wire logic i_upstream_done,
  output logic o_fault_line,
  output logic o_chain_ready
);
  logic [2:0] pull_q = 3'h0;
  logic rdy_q = 1'b0;
  // A peer pulls briefly, never holds the wire
  always_ff @(posedge i_clk) pull_q <= i_fault_req ? 3'h4 : pull_q - 3'(pull_q != 3'h0);
  // Pull-up wire: low while any party pulls
  assign o_fault_line = !(i_dut_oe || pull_q != 3'h0);
  // Upstream reset frees us only once that group is on
  always_ff @(posedge i_clk) rdy_q <= i_upstream_done;
  // Peer loads needing one edge share one drive, so no skew here
  assign o_chain_ready = rdy_q;
endmodule : css_peer_model

// ===== bench/testbench.sv
// Self-checking bench for the cascaded supply sequencer
`timescale 1ns/1ps
module testbench;
  localparam int ST = 20;
  logic clk = 0, rst = 1, en = 0, go = 1, freq = 0, oe, fo, fl, rdy, rst_n;
  logic [3:0] uv = 4'hF, drv;
  int n_fail = 0, n_checks = 0, t[4];
  always #20 clk = ~clk;
  css_sequencer #(.START_CYC(ST), .LOCKOUT_CYC(30), .RELEASE_CYC(30)) u_css_sequencer (
    .I_MCLK(clk), .I_SYS_RST(rst), .I_ENABLE(en), .I_CHAIN_READY(rdy), .I_UNDERVOLTAGE_INPUT_OK(uv),
    .I_SHARED_FAULT_LINE(fl), .I_ON_DELAY({24'h23, 24'h19, 24'h0F, 24'h05}),
    .I_OFF_DELAY({24'h00, 24'h0A, 24'h14, 24'h1E}), .O_SWITCH_DRIVE(drv),
    .O_SHARED_FAULT_LINE_OE(oe), .O_SHARED_FAULT_LINE(fo), .O_RESET_N(rst_n));
  css_peer_model u_css_peer_model (.i_clk(clk), .i_dut_oe(oe), .i_fault_req(freq),
    .i_upstream_done(go), .o_fault_line(fl), .o_chain_ready(rdy));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %0h not %0h", $time, seen, exp);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Cycle of the first change of each drive bit within n cycles
  task watch(input int n);
    logic [3:0] s;
    s = drv;
    t = '{-1, -1, -1, -1};
    for (int c = 0; c < n; c++) begin
      @(negedge clk);
      for (int g = 0; g < 4; g++) if (t[g] < 0 && drv[g] !== s[g]) t[g] = c;
    end
  endtask : watch
  task wait_rn(input int n);
    for (int c = 0; c < n && rst_n !== 1'b1; c++) @(negedge clk);
  endtask : wait_rn
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_on;
    en = 1;
    watch(ST + 45);
    chk(t[0] >= ST, 1);
    for (int g = 1; g < 4; g++) chk(t[g] - t[0], 10 * g);
    chk(rst_n, 0);
    wait_rn(80);
    chk(rst_n, 1);
    $display("on test done");
  endtask : t_on
  task t_off;
    en = 0;
    @(negedge clk);
    chk(rst_n, 0);
    watch(40);
    for (int g = 0; g < 3; g++) chk(t[g] - t[3], 30 - 10 * g);
    chk(drv, 0);
    $display("off test done");
  endtask : t_off
  task t_uv;
    uv = 4'hB;
    en = 1;
    repeat (ST + 150) @(negedge clk);
    chk(rst_n, 0);
    uv = 4'hF;
    wait_rn(100);
    uv = 4'hE;
    repeat (2) @(negedge clk);
    chk({oe, fo}, 2'b10);
    repeat (6) @(negedge clk);
    chk({drv, oe}, 0);
    en = 0;
    uv = 4'hF;
    repeat (50) @(negedge clk);
    $display("undervoltage test done");
  endtask : t_uv
  task t_chain;
    go = 0;
    // Ready is registered in the upstream model; let it fall before enabling
    @(negedge clk);
    en = 1;
    repeat (ST + 60) @(negedge clk);
    chk(drv, 0);
    go = 1;
    wait_rn(200);
    chk(rst_n, 1);
    freq = 1;
    @(negedge clk);
    freq = 0;
    repeat (6) @(negedge clk);
    chk(drv, 0);
    en = 0;
    repeat (50) @(negedge clk);
    $display("chain test done");
  endtask : t_chain
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    chk({drv, oe, fo, rst_n}, 0);
    t_on;
    t_off;
    t_uv;
    t_chain;
    report_and_stop;
  end
  // Whole run needs under 1500 cycles
  initial begin
    #120000;
    n_fail++;
    report_and_stop;
  end
endmodule : testbench
